//--- rtl/ontime_loop_defines.svh
// Register offsets, writable masks, reset values and timing counts of the on-time loop block.
// Assumes nothing; included by rtl files by bare name.
`ifndef ONTIME_LOOP_DEFINES_SVH
`define ONTIME_LOOP_DEFINES_SVH

// Register command codes
`define REG_DECREASE_WEIGHTS 8'h32
`define REG_RECOVERY_WEIGHTS 8'h33
`define REG_INPUT_DROP       8'h34
`define REG_START_THRESHOLD  8'h35
`define REG_STOP_THRESHOLD   8'h36

// Writable masks per register
`define MASK_DECREASE  16'hffff
`define MASK_RECOVERY  16'hffff
`define MASK_DROP      16'h1fff
`define MASK_THRESHOLD 16'h01ff

// Reset values
`define RST_DECREASE   16'h0000
`define RST_RECOVERY   16'h0000
`define RST_DROP       16'h0000
`define RST_START      16'h0000
`define RST_STOP       16'h0000

// Blanking step and clock period in ps
`define BLANK_STEP_PS  20'h01388
`define CLOCK_PS       20'h04e20

// Protection and start delay counts in clock cycles
`define PROTECT_DELAY_CYCLES 16'h0010
`define START_DELAY_CYCLES   16'h0010
`endif

//--- rtl/ontime_loop_pkg.sv
// Types shared by the on-time loop files.
// Needs no defines; the state encodings are literals here.
package ontime_loop_pkg;
  typedef enum logic [1:0]
  {
    ST_LOCKED  = 2'b00,
    ST_PROTECT = 2'b01,
    ST_START   = 2'b11,
    ST_RUN     = 2'b10
  } start_state_t;
endpackage

//--- rtl/input_sag_detect.sv
// Rectifier skip/resume hysteresis comparator on sensed input and output.
// Assumes sense readings are synchronous to i_clock.
`timescale 1ns/10ps
module input_sag_detect
(
  input  wire logic       i_clock,      // System clock
  input  wire logic       i_arst_n,     // Async reset, active low
  input  wire logic [8:0] i_input_sense, // Input reading
  input  wire logic [8:0] i_output_sense, // Output reading
  input  wire logic [3:0] i_skip_delta, // Low-input skip delta
  input  wire logic [3:0] i_resume_margin, // Resume margin
  output logic            o_skip        // High while skipping
);
  // Widen to avoid wrap at the ends of the scale
  wire logic [9:0] skip_level   = {1'b0, i_output_sense} - {6'h00, i_skip_delta};
  wire logic [9:0] resume_level = {1'b0, i_output_sense} + {6'h00, i_resume_margin};
  wire logic       below = (i_output_sense >= {5'h00, i_skip_delta}) &&
                           ({1'b0, i_input_sense} < skip_level);
  wire logic       above = {1'b0, i_input_sense} > resume_level;
  logic            skip_q;

  // Hysteresis between the two thresholds
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
      skip_q <= 1'b0;
    else if (below)
      skip_q <= 1'b1;
    else if (above)
      skip_q <= 1'b0;
  end
  assign o_skip = skip_q;

  a_skip_start: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    below |=> o_skip) else $error("skip did not start");
  a_skip_resume: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (above && !below) |=> !o_skip) else $error("skip did not end");
endmodule

//--- rtl/ontime_loop.sv
// On-time adjustment loop, rectifier skip control and input lockout sequencing.
// Assumes register writes and sense values come from logic on i_clock;
// spike flags and set pulse arrive from pins and are synchronised here.
// What this block does
// - Low-side spike cuts on-time by its weight
// - Missing set pulse cuts on-time by weight while blanking is zero
// - High-side spike release restores on-time by weight
// - Low-side spike release restores on-time by weight
// - Reserved writable bits store but do nothing
// - Input below output minus delta skips rectifier
// - Input above output plus margin resumes rectifier
// - Start waits protect delay then start delay
// - Lockout when at/below start off, below stop
// - Thresholds are 9-bit quarter-volt readings
// - Blanking at period start masks set pulses; nonzero blanking stops missing-set cuts
`timescale 1ns/10ps
`include "ontime_loop_defines.svh"
module ontime_loop
(
  input  wire logic        i_clock,         // 50 MHz clock
  input  wire logic        i_arst_n,        // Async reset, active low
  input  wire logic        i_wr_en,         // Register write strobe
  input  wire logic [7:0]  i_reg_addr,      // Command code
  input  wire logic [15:0] i_wr_data,       // Write data
  output logic      [15:0] o_rd_data,       // Read data, registered
  input  wire logic        i_first_sense_spike_flag,  // Spike on first sense
  input  wire logic        i_second_sense_spike_flag, // Spike on second sense
  input  wire logic        i_period_start,  // Primary period start pulse
  input  wire logic        i_set_pulse,     // Set pulse from sensing
  input  wire logic [5:0]  i_loop_blanking_time, // Blanking, 5 ns steps
  input  wire logic [9:0]  i_ontime_min,    // Lower on-time limit
  input  wire logic [9:0]  i_ontime_max,    // Upper on-time limit
  input  wire logic [8:0]  i_input_sense,   // Measured input reading
  input  wire logic [8:0]  i_output_sense,  // Measured output reading
  output logic      [9:0]  o_ontime,        // Current on-time
  output logic             o_rectifier_skip, // Rectifier pulses skipped
  output logic             o_uvlo,          // Input lockout active
  output logic             o_pwm_enable     // PWM outputs allowed
);
  // Register storage
  logic [15:0] decrease_q;   // Decrease weights
  logic [15:0] recovery_q;   // Recovery weights
  logic [15:0] drop_q;       // Input drop control
  logic [15:0] start_thr_q;  // Start threshold
  logic [15:0] stop_thr_q;   // Stop threshold
  logic [15:0] rd_data_q;    // Read data

  // Field views; reserved bits are stored but never used
  wire logic [7:0] low_spike_decrease_weight = decrease_q[15:8];
  wire logic [7:0] no_set_decrease_weight    = decrease_q[7:0];
  wire logic [6:0] high_spike_recovery_weight = recovery_q[14:8];
  wire logic [6:0] low_spike_recovery_weight  = recovery_q[6:0];
  wire logic [3:0] low_input_skip_delta     = drop_q[7:4];
  wire logic [3:0] rectifier_resume_margin  = drop_q[3:0];
  wire logic [8:0] start_level = start_thr_q[8:0];
  wire logic [8:0] stop_level  = stop_thr_q[8:0];

  // Write decode, masked per register
  function automatic logic [15:0] masked(input logic [15:0] d, input logic [15:0] m);
    masked = d & m;
  endfunction

  wire logic wr_dec   = i_wr_en && (i_reg_addr == `REG_DECREASE_WEIGHTS);
  wire logic wr_rec   = i_wr_en && (i_reg_addr == `REG_RECOVERY_WEIGHTS);
  wire logic wr_drop  = i_wr_en && (i_reg_addr == `REG_INPUT_DROP);
  wire logic wr_start = i_wr_en && (i_reg_addr == `REG_START_THRESHOLD);
  wire logic wr_stop  = i_wr_en && (i_reg_addr == `REG_STOP_THRESHOLD);

  // Register writes; reserved R/W bits simply keep what was written
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      decrease_q  <= `RST_DECREASE;
      recovery_q  <= `RST_RECOVERY;
      drop_q      <= `RST_DROP;
      start_thr_q <= `RST_START;
      stop_thr_q  <= `RST_STOP;
    end
    else
    begin
      if (wr_dec)
        decrease_q <= masked(i_wr_data, `MASK_DECREASE);
      if (wr_rec)
        recovery_q <= masked(i_wr_data, `MASK_RECOVERY);
      if (wr_drop)
        drop_q <= masked(i_wr_data, `MASK_DROP);
      if (wr_start)
        start_thr_q <= masked(i_wr_data, `MASK_THRESHOLD);
      if (wr_stop)
        stop_thr_q <= masked(i_wr_data, `MASK_THRESHOLD);
    end
  end

  // Read mux; unmapped codes read zero
  wire logic [15:0] rd_sel =
    (i_reg_addr == `REG_DECREASE_WEIGHTS) ? decrease_q  :
    (i_reg_addr == `REG_RECOVERY_WEIGHTS) ? recovery_q  :
    (i_reg_addr == `REG_INPUT_DROP)       ? drop_q      :
    (i_reg_addr == `REG_START_THRESHOLD)  ? start_thr_q :
    (i_reg_addr == `REG_STOP_THRESHOLD)   ? stop_thr_q  : 16'h0000;

  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
      rd_data_q <= 16'h0000;
    else
      rd_data_q <= rd_sel;
  end
  assign o_rd_data = rd_data_q;

  // Two-flop synchronisers for pin inputs, one generate per bit
  wire logic [2:0] pin_raw = {i_set_pulse, i_second_sense_spike_flag, i_first_sense_spike_flag};
  logic [2:0] meta_q;   // First stage, read only by second
  logic [2:0] sync_q;   // Second stage
  logic [2:0] prev_q;   // Previous synced value for edges
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_sync
      always_ff @(posedge i_clock or negedge i_arst_n)
      begin
        if (!i_arst_n)
        begin
          meta_q[g] <= 1'b0;
          sync_q[g] <= 1'b0;
          prev_q[g] <= 1'b0;
        end
        else
        begin
          meta_q[g] <= pin_raw[g];
          sync_q[g] <= meta_q[g];
          prev_q[g] <= sync_q[g];
        end
      end
    end
  endgenerate

  wire logic high_release = prev_q[0] && !sync_q[0];
  wire logic low_rise     = sync_q[1] && !prev_q[1];
  wire logic low_release  = prev_q[1] && !sync_q[1];
  wire logic set_rise     = sync_q[2] && !prev_q[2];

  // Blanking length in clock cycles, from 5 ns steps, rounded up
  wire logic [19:0] blank_ps     = 20'(i_loop_blanking_time) * `BLANK_STEP_PS;
  wire logic [19:0] blank_cycles = (blank_ps + `CLOCK_PS - 20'd1) / `CLOCK_PS;
  wire logic        blank_off    = (i_loop_blanking_time == 6'h00);

  logic [19:0] period_cnt_q;  // Cycles since period start
  logic        saw_set_q;     // Set pulse seen this period
  logic        in_period_q;   // A period has begun

  wire logic blanked    = !blank_off && (period_cnt_q < blank_cycles);
  wire logic set_count  = set_rise && !blanked;
  wire logic no_set_end = i_period_start && in_period_q && !saw_set_q && blank_off;

  // Period tracking for missing set detection
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      period_cnt_q <= 20'h00000;
      saw_set_q    <= 1'b0;
      in_period_q  <= 1'b0;
    end
    else if (i_period_start)
    begin
      period_cnt_q <= 20'h00000;
      saw_set_q    <= 1'b0;
      in_period_q  <= 1'b1;
    end
    else
    begin
      if (period_cnt_q != 20'hfffff)
        period_cnt_q <= period_cnt_q + 20'h00001;
      if (set_count)
        saw_set_q <= 1'b1;
    end
  end

  logic [9:0] ontime_q;   // On-time accumulator, read by the adder below

  // Net adjustment; decreases and recoveries combine in one step
  wire logic [11:0] dec_amt = (low_rise ? {4'h0, low_spike_decrease_weight} : 12'h000)
                            + (no_set_end ? {4'h0, no_set_decrease_weight} : 12'h000);
  wire logic [11:0] inc_amt = (high_release ? {5'h00, high_spike_recovery_weight} : 12'h000)
                            + (low_release ? {5'h00, low_spike_recovery_weight} : 12'h000);
  wire logic [12:0] raised  = {3'h0, ontime_q} + {1'b0, inc_amt};
  wire logic [12:0] lowered = (raised >= {1'b0, dec_amt}) ? raised - {1'b0, dec_amt} : 13'h0000;
  wire logic [9:0]  ontime_d =
    (lowered < {3'h0, i_ontime_min}) ? i_ontime_min :
    (lowered > {3'h0, i_ontime_max}) ? i_ontime_max : lowered[9:0];

  // On-time register; clamp keeps it inside the limits after reset too
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
      ontime_q <= 10'h000;
    else
      ontime_q <= ontime_d;
  end
  assign o_ontime = ontime_q;

  // Rectifier skip comparator
  input_sag_detect u_sag
  (
    .i_clock         (i_clock),
    .i_arst_n        (i_arst_n),
    .i_input_sense   (i_input_sense),
    .i_output_sense  (i_output_sense),
    .i_skip_delta    (low_input_skip_delta),
    .i_resume_margin (rectifier_resume_margin),
    .o_skip          (o_rectifier_skip)
  );

  // Lockout: power off uses start level, running uses stop level
  ontime_loop_pkg::start_state_t state_q;
  ontime_loop_pkg::start_state_t state_d;
  logic [15:0] delay_q;  // Delay counter
  wire logic power_on = (state_q == ontime_loop_pkg::ST_RUN);
  wire logic uvlo = (!power_on && (i_input_sense <= start_level)) ||
                    (i_input_sense < stop_level);
  wire logic delay_done = (delay_q == 16'h0000);

  // Start sequence next state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ontime_loop_pkg::ST_LOCKED:
        if (!uvlo)
          state_d = ontime_loop_pkg::ST_PROTECT;
      ontime_loop_pkg::ST_PROTECT:
        if (uvlo)
          state_d = ontime_loop_pkg::ST_LOCKED;
        else if (delay_done)
          state_d = ontime_loop_pkg::ST_START;
      ontime_loop_pkg::ST_START:
        if (uvlo)
          state_d = ontime_loop_pkg::ST_LOCKED;
        else if (delay_done)
          state_d = ontime_loop_pkg::ST_RUN;
      ontime_loop_pkg::ST_RUN:
        if (uvlo)
          state_d = ontime_loop_pkg::ST_LOCKED;
      default:
        state_d = ontime_loop_pkg::ST_LOCKED;
    endcase
  end

  // State and delay counter; counter reloads on every state change
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state_q <= ontime_loop_pkg::ST_LOCKED;
      delay_q <= `PROTECT_DELAY_CYCLES;
    end
    else
    begin
      state_q <= state_d;
      if (state_d != state_q)
        delay_q <= (state_d == ontime_loop_pkg::ST_START) ? `START_DELAY_CYCLES : `PROTECT_DELAY_CYCLES;
      else if (!delay_done)
        delay_q <= delay_q - 16'h0001;
    end
  end

  assign o_uvlo       = uvlo;
  assign o_pwm_enable = power_on;

  // Checks
  a_low_spike_cut: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (low_rise && !high_release && !low_release && !no_set_end && ontime_q >= i_ontime_min
     && ontime_q <= i_ontime_max && {2'b00, ontime_q} >= ({4'h0, low_spike_decrease_weight} + {2'b00, i_ontime_min}))
    |=> ontime_q == $past(ontime_q) - {2'b00, $past(low_spike_decrease_weight)})
    else $error("low spike cut wrong");
  a_no_set_cut: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (no_set_end && !low_rise && !high_release && !low_release && ontime_q <= i_ontime_max
     && {2'b00, ontime_q} >= ({2'b00, no_set_decrease_weight} + {2'b00, i_ontime_min}))
    |=> ontime_q == $past(ontime_q) - {2'b00, $past(no_set_decrease_weight)})
    else $error("no set cut wrong");
  a_high_recover: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (high_release && !low_release && !low_rise && !no_set_end && ontime_q >= i_ontime_min
     && ({1'b0, ontime_q} + {4'h0, high_spike_recovery_weight}) <= {1'b0, i_ontime_max})
    |=> ontime_q == $past(ontime_q) + {3'h0, $past(high_spike_recovery_weight)})
    else $error("high recovery wrong");
  a_low_recover: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (low_release && !high_release && !no_set_end && ontime_q >= i_ontime_min
     && ({1'b0, ontime_q} + {4'h0, low_spike_recovery_weight}) <= {1'b0, i_ontime_max})
    |=> ontime_q == $past(ontime_q) + {3'h0, $past(low_spike_recovery_weight)})
    else $error("low recovery wrong");
  a_reserved_keep: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    wr_drop |=> drop_q[12:8] == $past(i_wr_data[12:8]))
    else $error("reserved bits lost");
  a_uvlo_stop: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (i_input_sense < stop_level) |-> o_uvlo)
    else $error("lockout missed");
  a_start_order: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    $rose(o_pwm_enable) |-> $past(state_q) == ontime_loop_pkg::ST_START && $past(delay_done))
    else $error("start skipped delay");
  a_ontime_bound: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (i_ontime_min <= i_ontime_max) |=> (ontime_q >= $past(i_ontime_min)) && (ontime_q <= $past(i_ontime_max)))
    else $error("on-time out of bounds");
  a_blank_hold: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (blanked && !i_period_start && !saw_set_q) |=> !saw_set_q)
    else $error("set counted in blanking");
endmodule

//--- bench/reg_host_model.sv
// Host model that programs and reads the command registers of the loop block.
// Assumes a one-cycle write strobe and one edge of read latency after the address.
`timescale 1ns/10ps
module reg_host_model
(
  input  wire logic        i_clock,    // System clock
  input  wire logic [15:0] i_rd_data,  // Read data from block
  output logic             o_wr_en,    // Write strobe
  output logic      [7:0]  o_reg_addr, // Command code
  output logic      [15:0] o_wr_data   // Write data
);
  // Idle bus from time zero
  initial
  begin
    o_wr_en    = 1'b0;
    o_reg_addr = 8'h00;
    o_wr_data  = 16'h0000;
  end

  // One-cycle write; data turned over after release so stale data never passes
  task automatic write_reg(input logic [7:0] addr, input logic [15:0] data);
    @(posedge i_clock);
    o_wr_en    <= 1'b1;
    o_reg_addr <= addr;
    o_wr_data  <= data;
    @(posedge i_clock);
    o_wr_en    <= 1'b0;
    o_wr_data  <= ~data;
  endtask

  // Address held across the read flop's edge, sampled mid-cycle
  task automatic read_reg(input logic [7:0] addr, output logic [15:0] data);
    @(posedge i_clock);
    o_reg_addr <= addr;
    @(posedge i_clock);
    @(negedge i_clock);
    data = i_rd_data;
  endtask
endmodule

//--- bench/ontime_loop_tb.sv
// Self-checking bench for the on-time loop block.
// Assumes the host model drives the register port; pins are driven here.
`timescale 1ns/10ps
module ontime_loop_tb;
  logic        clock;        // 50 MHz clock
  logic        arst_n;       // Reset, active low
  logic        wr_en;        // From host model
  logic [7:0]  reg_addr;     // From host model
  logic [15:0] wr_data;      // From host model
  logic [15:0] rd_data;      // Read data
  logic        spike_first;  // First sense spike pin
  logic        spike_second; // Second sense spike pin
  logic        period_start; // Period start pulse
  logic        set_pulse;    // Set pin
  logic [5:0]  blank_time;   // Blanking setting
  logic [9:0]  ontime_min;   // Lower limit
  logic [9:0]  ontime_max;   // Upper limit
  logic [8:0]  input_sense;  // Input reading
  logic [8:0]  output_sense; // Output reading
  logic [9:0]  ontime;       // On-time out
  logic        rect_skip;    // Skip flag
  logic        uvlo;         // Lockout flag
  logic        pwm_enable;   // Run flag
  int          n_mismatch;   // Mismatch count
  int          n_tests;      // Comparison count

  reg_host_model u_host
  (
    .i_clock    (clock),
    .i_rd_data  (rd_data),
    .o_wr_en    (wr_en),
    .o_reg_addr (reg_addr),
    .o_wr_data  (wr_data)
  );

  ontime_loop u_dut
  (
    .i_clock                   (clock),
    .i_arst_n                  (arst_n),
    .i_wr_en                   (wr_en),
    .i_reg_addr                (reg_addr),
    .i_wr_data                 (wr_data),
    .o_rd_data                 (rd_data),
    .i_first_sense_spike_flag  (spike_first),
    .i_second_sense_spike_flag (spike_second),
    .i_period_start            (period_start),
    .i_set_pulse               (set_pulse),
    .i_loop_blanking_time      (blank_time),
    .i_ontime_min              (ontime_min),
    .i_ontime_max              (ontime_max),
    .i_input_sense             (input_sense),
    .i_output_sense            (output_sense),
    .o_ontime                  (ontime),
    .o_rectifier_skip          (rect_skip),
    .o_uvlo                    (uvlo),
    .o_pwm_enable              (pwm_enable)
  );

  // Free-running clock
  always #10 clock = ~clock;

  // Vector and flag comparisons, four-state exact
  task automatic chk_vec(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_bit(input string name, input logic exp, input logic got);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask

  // Let n edges land, then sample mid-cycle
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask

  // Reset values, masks of read-only bits and an unmapped code
  task automatic t_registers();
    logic [7:0]  addr [6] = '{8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37};
    logic [15:0] mask [6] = '{16'hffff, 16'hffff, 16'h1fff, 16'h01ff, 16'h01ff, 16'h0000};
    logic [15:0] rd;
    for (int k = 0; k < 6; k++)
    begin
      u_host.read_reg(addr[k], rd);
      chk_vec("reset value", 16'h0000, rd);
      u_host.write_reg(addr[k], 16'hffff);
      u_host.read_reg(addr[k], rd);
      chk_vec("read back", mask[k], rd);
    end
  endtask

  // Lockout boundaries, start sequence and hysteresis while running
  task automatic t_lockout();
    int n;
    u_host.write_reg(8'h35, 16'h0100);
    u_host.write_reg(8'h36, 16'h00c0);
    @(posedge clock);
    input_sense <= 9'h100;
    wait_cyc(2);
    chk_bit("lockout at start level", 1'b1, uvlo);
    @(posedge clock);
    input_sense <= 9'h101;
    n = 0;
    wait_cyc(0);
    chk_bit("lockout above start", 1'b0, uvlo);
    while (pwm_enable !== 1'b1 && n < 60)
    begin
      wait_cyc(1);
      n++;
    end
    // Two 16-cycle delays must pass before the outputs run
    chk_bit("start delay length", 1'b1, n >= 30 && n <= 36);
    @(posedge clock);
    input_sense <= 9'h0c0;
    wait_cyc(2);
    chk_bit("no lockout at stop level", 1'b0, uvlo);
    chk_bit("still running", 1'b1, pwm_enable);
    @(posedge clock);
    input_sense <= 9'h0bf;
    wait_cyc(2);
    chk_bit("lockout below stop", 1'b1, uvlo);
    chk_bit("outputs stopped", 1'b0, pwm_enable);
    @(posedge clock);
    input_sense <= 9'h0c0;
    wait_cyc(2);
    chk_bit("lockout while off", 1'b1, uvlo);
  endtask

  // Skip and resume edges, reserved bits set to prove they are inert
  task automatic t_skip();
    logic [8:0]  vin [4] = '{9'h0fc, 9'h0fb, 9'h103, 9'h104};
    logic        exp [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    logic [15:0] rd;
    u_host.write_reg(8'h34, 16'h1f43);
    u_host.read_reg(8'h34, rd);
    chk_vec("reserved bits kept", 16'h1f43, rd);
    @(posedge clock);
    output_sense <= 9'h100;
    input_sense  <= 9'h104;
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clock);
      input_sense <= vin[k];
      wait_cyc(3);
      chk_bit("rectifier skip", exp[k], rect_skip);
    end
  endtask

  // Spike decrease, both recoveries and clamping at the limits
  task automatic t_spikes();
    logic [9:0] exp;
    u_host.write_reg(8'h32, 16'h2505);
    u_host.write_reg(8'h33, 16'ha090);
    exp = 10'h010;
    chk_vec("clamped to minimum", {6'h00, exp}, {6'h00, ontime});
    for (int k = 0; k < 5; k++)
    begin
      @(posedge clock);
      spike_first <= 1'b1;
      wait_cyc(6);
      @(posedge clock);
      spike_first <= 1'b0;
      wait_cyc(6);
      exp = (exp + 10'h020 > 10'h080) ? 10'h080 : exp + 10'h020;
      chk_vec("first recovery", {6'h00, exp}, {6'h00, ontime});
    end
    @(posedge clock);
    spike_second <= 1'b1;
    wait_cyc(6);
    chk_vec("second decrease", 16'h005b, {6'h00, ontime});
    @(posedge clock);
    spike_second <= 1'b0;
    wait_cyc(6);
    chk_vec("second recovery", 16'h006b, {6'h00, ontime});
  endtask

  // One period start pulse, then settle
  task automatic period();
    @(posedge clock);
    period_start <= 1'b1;
    @(posedge clock);
    period_start <= 1'b0;
    wait_cyc(4);
  endtask

  // Missing set pulse with and without blanking
  task automatic t_missing_set();
    logic [9:0] v;
    period();
    v = ontime;
    period();
    chk_vec("missing set decrease", {6'h00, v - 10'h005}, {6'h00, ontime});
    @(posedge clock);
    set_pulse <= 1'b1;
    wait_cyc(3);
    @(posedge clock);
    set_pulse <= 1'b0;
    wait_cyc(4);
    period();
    chk_vec("set seen, no change", {6'h00, v - 10'h005}, {6'h00, ontime});
    @(posedge clock);
    blank_time <= 6'h3f;
    period();
    wait_cyc(30);
    period();
    chk_vec("blanking holds loop", {6'h00, v - 10'h005}, {6'h00, ontime});
  endtask

  task automatic print_verdict();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Main sequence: inputs quiet at time zero, reset for 10 cycles
  initial
  begin
    clock        = 1'b0;
    arst_n       = 1'b0;
    spike_first  = 1'b0;
    spike_second = 1'b0;
    period_start = 1'b0;
    set_pulse    = 1'b0;
    blank_time   = 6'h00;
    ontime_min   = 10'h010;
    ontime_max   = 10'h080;
    input_sense  = 9'h000;
    output_sense = 9'h000;
    n_mismatch   = 0;
    n_tests      = 0;
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    t_registers();
    t_lockout();
    t_skip();
    t_spikes();
    t_missing_set();
    print_verdict();
  end

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    print_verdict();
  end
endmodule
